// *** module_info_map.svh ***
`ifndef MODULE_INFO_MAP_SVH
`define MODULE_INFO_MAP_SVH

// two-wire slave address: fixed device-type code and hard-wired select bits
`define DEV_TYPE 4'hA
`define DEV_SEL 3'h0
// slave address byte fields: type code, select bits, read/write bit
`define TYPE_HI 7
`define TYPE_LO 4
`define SEL_HI 3
`define SEL_LO 1
`define RW_BIT 0

// storage geometry: 8-bit counter over 256 byte locations
`define ADDR_W 8
`define BYTE_W 8
`define ADDR_ONE 8'h01
`define ADDR_MAX 8'hFF
`define CTR_RST 8'h00

// bit counter within one byte
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define CNT_LAST 4'h7
`define CNT_FULL 4'h8

// bytes owed to the link that must be thrown away after an abort
`define STALE_ZERO 2'h0
`define STALE_ONE 2'h1

// two-entry crossing buffer pointers: one index bit plus a wrap bit
`define PTR_W 2
`define PTR_ONE 2'h1
`define PTR_ZERO 2'h0

`endif

// *** module_info_pkg.sv ***
`include "module_info_map.svh"

package module_info_pkg;

	// link engine states, one-hot
	typedef enum logic [10:0] {
		L_IDLE = 11'h001,
		L_ADDR = 11'h002,
		L_ADDR_ACK = 11'h004,
		L_WADDR = 11'h008,
		L_WADDR_ACK = 11'h010,
		L_WDATA = 11'h020,
		L_WDATA_ACK = 11'h040,
		L_TX_LOAD = 11'h080,
		L_TX = 11'h100,
		L_TX_ACK = 11'h200,
		L_WAIT = 11'h400
	} link_state_e;

	// all state clocked by the link clock
	typedef struct packed {
		logic rst_q1;
		logic rst_q2;
		logic scl_q1;
		logic scl_q2;
		logic scl_q3;
		logic sda_q1;
		logic sda_q2;
		logic sda_q3;
		link_state_e state;
		logic [3:0] cnt;
		logic [`BYTE_W-1:0] shreg;
		logic [`ADDR_W-1:0] ctr;
		logic is_read;
		logic ack_seen;
		logic oe;
		logic req_tgl;
		logic [`ADDR_W-1:0] req_addr;
		logic owe;
		logic [1:0] stale;
	} link_s;

	// all state clocked by the core clock, storage included
	typedef struct packed {
		logic tg_q1;
		logic tg_q2;
		logic tg_q3;
		logic pend;
		logic [`ADDR_W-1:0] addr;
		logic [255:0][`BYTE_W-1:0] mem;
	} core_s;

	// crossing buffer, write side
	typedef struct packed {
		logic [`PTR_W-1:0] wbin;
		logic [`PTR_W-1:0] wgray;
		logic [`PTR_W-1:0] rq1;
		logic [`PTR_W-1:0] rq2;
		logic [1:0][`BYTE_W-1:0] mem;
	} fifo_wr_s;

	// crossing buffer, read side
	typedef struct packed {
		logic [`PTR_W-1:0] rbin;
		logic [`PTR_W-1:0] rgray;
		logic [`PTR_W-1:0] wq1;
		logic [`PTR_W-1:0] wq2;
	} fifo_rd_s;

endpackage : module_info_pkg

// *** byte_cross_fifo.sv ***
`include "module_info_map.svh"

module byte_cross_fifo (
	input wire logic wr_clk_i,
	input wire logic wr_nrst_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [`BYTE_W-1:0] wr_data_i,
	input wire logic rd_clk_i,
	input wire logic rd_nrst_i,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [`BYTE_W-1:0] rd_data_o
);
	import module_info_pkg::*;

	fifo_wr_s wr_r, wr_nxt;
	fifo_rd_s rd_r, rd_nxt;
	logic [`PTR_W-1:0] wbin_inc;
	logic [`PTR_W-1:0] rbin_inc;

	// full when the far pointer is exactly two entries behind (gray form)
	assign wr_ready_o = (wr_r.wgray != ~wr_r.rq2);
	assign rd_valid_o = (rd_r.rgray != rd_r.wq2);
	// entry is stable here: the write pointer only moved after it was filled
	assign rd_data_o = wr_r.mem[rd_r.rbin[0]];
	assign wbin_inc = wr_r.wbin + `PTR_ONE;
	assign rbin_inc = rd_r.rbin + `PTR_ONE;

	// write side: store, bump pointer, bring read pointer over
	always_comb begin
		wr_nxt = wr_r;
		wr_nxt.rq1 = rd_r.rgray;
		wr_nxt.rq2 = wr_r.rq1;
		if (wr_valid_i && wr_ready_o) begin
			wr_nxt.mem[wr_r.wbin[0]] = wr_data_i;
			wr_nxt.wbin = wbin_inc;
			wr_nxt.wgray = {wbin_inc[1], wbin_inc[1] ^ wbin_inc[0]};
		end
		if (!wr_nrst_i) begin
			wr_nxt = '0;
		end
	end

	always_ff @(posedge wr_clk_i) begin
		wr_r <= wr_nxt;
	end

	// read side: pop, bump pointer, bring write pointer over
	always_comb begin
		rd_nxt = rd_r;
		rd_nxt.wq1 = wr_r.wgray;
		rd_nxt.wq2 = rd_r.wq1;
		if (rd_valid_o && rd_ready_i) begin
			rd_nxt.rbin = rbin_inc;
			rd_nxt.rgray = {rbin_inc[1], rbin_inc[1] ^ rbin_inc[0]};
		end
		if (!rd_nrst_i) begin
			rd_nxt = '0;
		end
	end

	always_ff @(posedge rd_clk_i) begin
		rd_r <= rd_nxt;
	end

endmodule : byte_cross_fifo

// *** module_info_eeprom.sv ***
`include "module_info_map.svh"

module module_info_eeprom (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic link_clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic load_we_i,
	input wire logic [`ADDR_W-1:0] load_addr_i,
	input wire logic [`BYTE_W-1:0] load_data_i
);
	import module_info_pkg::*;

	link_s lr, ln;
	core_s cr, cn;
	logic f_wr_valid, f_wr_ready, f_rd_valid, f_rd_ready;
	logic [`BYTE_W-1:0] f_rd_data;
	logic scl_rise, scl_fall, sda_now, start_cond, stop_cond;

	// open drain: the pin only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_o = lr.oe;

	// line events from the synchronised copies, never from the first stage
	assign scl_rise = lr.scl_q2 && !lr.scl_q3;
	assign scl_fall = !lr.scl_q2 && lr.scl_q3;
	assign sda_now = lr.sda_q2;
	assign start_cond = lr.scl_q2 && lr.scl_q3 && lr.sda_q3 && !lr.sda_q2;
	assign stop_cond = lr.scl_q2 && lr.scl_q3 && !lr.sda_q3 && lr.sda_q2;

	// core side: byte fetch on toggle request, plus the loading port
	always_comb begin
		cn = cr;
		cn.tg_q1 = lr.req_tgl;
		cn.tg_q2 = cr.tg_q1;
		cn.tg_q3 = cr.tg_q2;
		f_wr_valid = cr.pend;
		if (cr.pend && f_wr_ready) begin
			cn.pend = 1'b0;
		end
		// address was set in the link domain on the same edge as the toggle and holds until the next one
		if (cr.tg_q2 != cr.tg_q3) begin
			cn.pend = 1'b1;
			cn.addr = lr.req_addr;
		end
		if (load_we_i) begin
			cn.mem[load_addr_i] = load_data_i;
		end
		if (!nrst_i) begin
			cn = '0;
		end
	end

	always_ff @(posedge clock_i) begin
		cr <= cn;
	end

	// buffer holds the fetched byte until the link engine can take it
	byte_cross_fifo u_fifo (
		.wr_clk_i(clock_i),
		.wr_nrst_i(nrst_i),
		.wr_valid_i(f_wr_valid),
		.wr_ready_o(f_wr_ready),
		.wr_data_i(cr.mem[cr.addr]),
		.rd_clk_i(link_clk_i),
		.rd_nrst_i(lr.rst_q2),
		.rd_valid_o(f_rd_valid),
		.rd_ready_i(f_rd_ready),
		.rd_data_o(f_rd_data)
	);

	// link engine: slave bit timing, ack slots and the address counter
	always_comb begin
		ln = lr;
		f_rd_ready = 1'b0;
		ln.rst_q1 = nrst_i;
		ln.rst_q2 = lr.rst_q1;
		ln.scl_q1 = scl_i;
		ln.scl_q2 = lr.scl_q1;
		ln.scl_q3 = lr.scl_q2;
		ln.sda_q1 = sda_i;
		ln.sda_q2 = lr.sda_q1;
		ln.sda_q3 = lr.sda_q2;
		// bytes fetched for an aborted transfer are drained and dropped
		if (lr.stale != `STALE_ZERO && f_rd_valid) begin
			f_rd_ready = 1'b1;
			ln.stale = lr.stale - `STALE_ONE;
		end
		unique case (lr.state)
			L_IDLE, L_WAIT: begin
			end
			L_ADDR, L_WADDR, L_WDATA: begin
				if (scl_rise) begin
					ln.shreg = {lr.shreg[`BYTE_W-2:0], sda_now};
					ln.cnt = lr.cnt + `CNT_ONE;
				end else if (scl_fall && lr.cnt == `CNT_FULL) begin
					ln.cnt = `CNT_ZERO;
					ln.oe = 1'b1;
					if (lr.state == L_ADDR) begin
						ln.is_read = lr.shreg[`RW_BIT];
						ln.state = L_ADDR_ACK;
						if (lr.shreg[`TYPE_HI:`TYPE_LO] != `DEV_TYPE ||
							lr.shreg[`SEL_HI:`SEL_LO] != `DEV_SEL) begin
							ln.oe = 1'b0;
							ln.state = L_WAIT;
						end
					end else if (lr.state == L_WADDR) begin
						ln.ctr = lr.shreg;
						ln.state = L_WADDR_ACK;
					end else begin
						// written data is not stored, but the access counts
						ln.ctr = lr.ctr + `ADDR_ONE;
						ln.state = L_WDATA_ACK;
					end
				end
			end
			L_ADDR_ACK: begin
				if (scl_fall) begin
					ln.oe = 1'b0;
					if (lr.is_read) begin
						ln.req_tgl = !lr.req_tgl;
						ln.req_addr = lr.ctr;
						ln.ctr = lr.ctr + `ADDR_ONE;
						ln.owe = 1'b1;
						ln.state = L_TX_LOAD;
					end else begin
						ln.state = L_WADDR;
					end
				end
			end
			L_WADDR_ACK, L_WDATA_ACK: begin
				if (scl_fall) begin
					ln.oe = 1'b0;
					ln.state = L_WDATA;
				end
			end
			L_TX_LOAD: begin
				// fetch takes well under the low phase, so no stretch is needed
				if (lr.stale == `STALE_ZERO && f_rd_valid) begin
					f_rd_ready = 1'b1;
					ln.owe = 1'b0;
					ln.shreg = f_rd_data;
					ln.oe = !f_rd_data[`BYTE_W-1];
					ln.cnt = `CNT_ZERO;
					ln.state = L_TX;
				end
			end
			L_TX: begin
				if (scl_fall) begin
					if (lr.cnt == `CNT_LAST) begin
						ln.oe = 1'b0;
						ln.cnt = `CNT_ZERO;
						ln.state = L_TX_ACK;
					end else begin
						ln.shreg = {lr.shreg[`BYTE_W-2:0], 1'b0};
						ln.oe = !lr.shreg[`BYTE_W-2];
						ln.cnt = lr.cnt + `CNT_ONE;
					end
				end
			end
			L_TX_ACK: begin
				if (scl_rise) begin
					ln.ack_seen = !sda_now;
					if (!sda_now) begin
						ln.req_tgl = !lr.req_tgl;
						ln.req_addr = lr.ctr;
						ln.ctr = lr.ctr + `ADDR_ONE;
						ln.owe = 1'b1;
					end
				end else if (scl_fall) begin
					ln.state = lr.ack_seen ? L_TX_LOAD : L_WAIT;
				end
			end
		endcase
		// start and stop override any state; an unsent byte is not an access
		if (start_cond || stop_cond) begin
			ln.stale = ln.stale + {1'b0, ln.owe};
			if (ln.owe) begin
				ln.ctr = ln.ctr - `ADDR_ONE;
			end
			ln.owe = 1'b0;
			ln.oe = 1'b0;
			ln.cnt = `CNT_ZERO;
			ln.state = start_cond ? L_ADDR : L_IDLE;
		end
		if (!lr.rst_q2) begin
			ln = '0;
			ln.rst_q1 = nrst_i;
			ln.rst_q2 = lr.rst_q1;
			ln.ctr = `CTR_RST;
			ln.state = L_IDLE;
		end
	end

	always_ff @(posedge link_clk_i) begin
		lr <= ln;
	end

	default clocking cb @(posedge link_clk_i);
	endclocking
	default disable iff (!lr.rst_q2);

	sequence s_ack_sampled;
		lr.state == L_TX_ACK && scl_rise && !sda_now;
	endsequence

	sequence s_nack_closed;
		lr.state == L_TX_ACK && scl_fall && !lr.ack_seen;
	endsequence

	property p_more_after_ack;
		s_ack_sampled |=> $changed(lr.req_tgl) ##0 lr.owe;
	endproperty
	a_more_after_ack: assert property (p_more_after_ack)
		else $error("acknowledge did not request another byte");

	property p_bit_on_line;
		lr.state == L_TX |-> sda_oe_o == !lr.shreg[`BYTE_W-1];
	endproperty
	a_bit_on_line: assert property (p_bit_on_line)
		else $error("data line does not carry the current bit");

	property p_ascending;
		$changed(lr.req_tgl) |-> lr.ctr == 8'(lr.req_addr + `ADDR_ONE);
	endproperty
	a_ascending: assert property (p_ascending)
		else $error("counter is not one past the fetched location");

	property p_next_location;
		s_ack_sampled |=> lr.req_addr == $past(lr.ctr);
	endproperty
	a_next_location: assert property (p_next_location)
		else $error("next byte is not fetched from the counter");

	property p_wrap;
		s_ack_sampled ##0 lr.ctr == `ADDR_MAX |=>
			lr.ctr == `CTR_RST ##0 lr.req_addr == `ADDR_MAX;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("counter did not roll over after the top location");

	property p_current_addr;
		lr.state == L_ADDR_ACK && scl_fall && lr.is_read && !start_cond
			&& !stop_cond |=> lr.req_addr == $past(lr.ctr);
	endproperty
	a_current_addr: assert property (p_current_addr)
		else $error("current-address read did not use the counter");

	property p_nack_release;
		s_nack_closed |=> lr.state != L_TX_LOAD ##0 (!sda_oe_o) [*8];
	endproperty
	a_nack_release: assert property (p_nack_release)
		else $error("device kept sending after a missing acknowledge");

	property p_addr_match;
		lr.state == L_ADDR_ACK |->
			lr.shreg[`TYPE_HI:`TYPE_LO] == `DEV_TYPE &&
			lr.shreg[`SEL_HI:`SEL_LO] == `DEV_SEL;
	endproperty
	a_addr_match: assert property (p_addr_match)
		else $error("acknowledged a foreign slave address");

	property p_rollover;
		$changed(lr.req_tgl) && lr.req_addr == `ADDR_MAX |->
			lr.ctr == `CTR_RST;
	endproperty
	a_rollover: assert property (p_rollover)
		else $error("all-ones counter did not step to zero");

endmodule : module_info_eeprom

// *** two_wire_master.sv ***
module two_wire_master (
	output logic scl_o,
	output logic sda_oe_o,
	input wire logic sda_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// clock low time; a long one stalls the reader behind the device buffer
	int t_low = 1000;

	// idle bus: clock high, data released to the pull-up
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end

	// data moves only with the clock low, clear of the falling edge
	task automatic clk_bit(input logic b, output logic s);
		#100 sda_oe_o = ~b;
		#(t_low) scl_o = 1'b1;
		#250 s = sda_i;
		#250 scl_o = 1'b0;
	endtask : clk_bit

	// also serves as repeated start from a low clock
	task automatic start_cond();
		#100 sda_oe_o = 1'b0;
		#400 scl_o = 1'b1;
		#500 sda_oe_o = 1'b1;
		#500 scl_o = 1'b0;
	endtask : start_cond

	task automatic stop_cond();
		#100 sda_oe_o = 1'b1;
		#400 scl_o = 1'b1;
		#500 sda_oe_o = 1'b0;
		#2000;
	endtask : stop_cond

	// msb first; the ninth slot returns the receiver's acknowledge
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
		clk_bit(1'b1, ack);
	endtask : wr_byte

	// low in the ninth slot asks for more, released ends the read
	task automatic rd_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
		clk_bit(last, s);
	endtask : rd_byte
endmodule : two_wire_master

// *** tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import module_info_pkg::*;

	typedef struct {
		logic [1:0] mode;
		logic [7:0] addr;
		int n;
	} row_s;

	logic clk, lclk, nrst, we, sda_o, sda_oe, mst_oe, ack;
	logic [7:0] la, ld, ctr;
	logic [7:0] exp_mem [256];
	wire scl;
	int fail_count = 0;
	int total_checks = 0;
	// mode 0 current read, 1 random read, 2 one write then current read
	row_s rows [6] = '{'{2'h1, 8'h10, 3}, '{2'h0, 8'h00, 2},
		'{2'h1, 8'hFD, 5}, '{2'h1, 8'h7F, 2}, '{2'h2, 8'h40, 2},
		'{2'h0, 8'h00, 1}};
	logic [7:0] bad [2] = '{8'hB1, 8'hA3};

	// open drain: any enable pulls low, otherwise the pull-up wins
	wire sda_line = sda_oe ? sda_o : (mst_oe ? 1'b0 : 1'b1);

	module_info_eeprom module_info_eeprom_i (
		.clock_i(clk),
		.nrst_i(nrst),
		.link_clk_i(lclk),
		.scl_i(scl),
		.sda_i(sda_line),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe),
		.load_we_i(we),
		.load_addr_i(la),
		.load_data_i(ld)
	);

	two_wire_master two_wire_master_i (
		.scl_o(scl),
		.sda_oe_o(mst_oe),
		.sda_i(sda_line)
	);

	// core clock and an unrelated link clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#1.7;
		forever #3 lclk = ~lclk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		if (fail_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	// four core edges also cover the link side's two-flop sync
	task automatic do_reset();
		@(posedge clk);
		#1 nrst = 1'b0;
		repeat (4) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clk);
	endtask : do_reset

	task automatic load(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 we = 1'b1;
		la = a;
		ld = d;
		exp_mem[a] = d;
		@(posedge clk);
		#1 we = 1'b0;
	endtask : load

	task automatic do_read(input logic [1:0] mode, input logic [7:0] a,
		input int n);
		logic [7:0] b;
		if (mode != 2'h0) begin
			two_wire_master_i.start_cond();
			two_wire_master_i.wr_byte(8'hA0, ack);
			check({7'h00, ack}, 8'h00);
			two_wire_master_i.wr_byte(a, ack);
			check({7'h00, ack}, 8'h00);
			ctr = a;
			if (mode == 2'h2) begin
				two_wire_master_i.wr_byte(8'h33, ack);
				ctr = a + 8'h01;
				two_wire_master_i.stop_cond();
			end
		end
		two_wire_master_i.start_cond();
		two_wire_master_i.wr_byte(8'hA1, ack);
		check({7'h00, ack}, 8'h00);
		for (int i = 0; i < n; i++) begin
			two_wire_master_i.rd_byte(i == n - 1, b);
			check(b, exp_mem[ctr]);
			ctr = ctr + 8'h01;
		end
		// after the final byte the line must stay released
		#1000;
		check({7'h00, sda_oe}, 8'h00);
		two_wire_master_i.stop_cond();
	endtask : do_read

	// table pass first, then refusals, a stalled reader and a second reset
	initial begin
		nrst = 1'b0;
		we = 1'b0;
		la = 8'h00;
		ld = 8'h00;
		ctr = 8'h00;
		do_reset();
		for (int a = 0; a < 256; a++) load(8'(a), 8'(a) ^ 8'hC3);
		foreach (rows[r]) do_read(rows[r].mode, rows[r].addr, rows[r].n);
		foreach (bad[k]) begin
			two_wire_master_i.start_cond();
			two_wire_master_i.wr_byte(bad[k], ack);
			check({7'h00, ack}, 8'h01);
			two_wire_master_i.stop_cond();
		end
		two_wire_master_i.t_low = 4000;
		do_read(2'h1, 8'hA0, 3);
		two_wire_master_i.t_low = 1000;
		do_reset();
		foreach (exp_mem[a]) exp_mem[a] = 8'h00;
		ctr = 8'h00;
		load(8'h00, 8'h96);
		do_read(2'h0, 8'h00, 2);
		wrap_up();
	end

	// whole run needs about 0.82 ms; one millisecond keeps the cycle budget
	initial begin
		#1000000;
		fail_count++;
		wrap_up();
	end
endmodule : tb_top
